// file: bench/eic3_pins_model.sv
/* Model of the three external input pins.
   Assumes pulse() is called just after a rising edge. */
`timescale 1ns/100ps
module eic3_pins_model (
    input  wire logic       clk_i,
    output logic      [2:0] pins_o
);
    // Pins idle low between events
    initial begin
        pins_o = 3'h0;
    end
    // event per pulse
    // One high cycle gives both edges, so either edge select sees it
    task automatic pulse(input int idx);
        pins_o[idx] <= 1'b1;
        @(posedge clk_i);
        pins_o[idx] <= 1'b0;
        @(posedge clk_i);
    endtask
    // Holds a level, for one-sided edges and pin level reads
    task automatic level(input int idx, input logic v);
        pins_o[idx] <= v;
        @(posedge clk_i);
    endtask
endmodule

// file: bench/eic3_top_asserts.sv
/* Port checker for eic3_top.
   Assumes it is bound from the bench top. */
`timescale 1ns/100ps
module eic3_top_asserts
    import eic3_pkg::*;
#(
    parameter int ADDR_W = EIC3_ADDR_W
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_we_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_ack_o,
    input wire logic              ext_in1_i,
    input wire logic              ext_in2_i,
    input wire logic              ext_in3_i,
    input wire logic              irq_high_o,
    input wire logic              irq_low_o,
    input wire logic              irq_o
);
    logic       wrt;
    logic [2:0] pins;
    // Low byte write and pin vector
    assign wrt = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
    assign pins = {ext_in3_i, ext_in2_i, ext_in1_i};

    // Answer comes exactly one cycle after the request
    a_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i) ##1 !wb_ack_o) else $error("ack shape");
    // Reset leaves every output low
    a_rst_quiet: assert property (@(posedge clk_i) rst_i |=> !wb_ack_o && !irq_o
        && !irq_high_o && !irq_low_o && wb_dat_o == 32'h0000_0000) else $error("reset");
    a_lo_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(irq_low_o) |-> $past(wrt, 2)) else $error("low request dropped");
    a_hi_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(irq_high_o) |-> $past(wrt, 2)) else $error("high request dropped");
    a_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_o) |-> $past(wrt, 2) || $past(pins, 2) != $past(pins, 3))
        else $error("irq without cause");
    a_hi_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(irq_high_o) |-> $past(wrt, 2) || $past(pins, 2) != $past(pins, 3))
        else $error("high request without cause");
    // Read data moves only with a read answer
    a_dat_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
endmodule

// file: bench/eic3_top_tb.sv
/* Bench for eic3_top: register rows, then events and requests.
   Assumes the pin model and the checker compile first. */
`timescale 1ns/100ps
module eic3_top_tb;
    import eic3_pkg::*;
    typedef struct packed {
        logic [4:0]  off;
        logic [3:0]  sel;
        logic [31:0] wd;
        logic [31:0] ex;
    } eic3_row_s;
    logic        clk_i;
    logic        rst_i;
    logic [4:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        we;
    logic [3:0]  sel;
    logic        cyc;
    logic        stb;
    logic        ack;
    logic [2:0]  pins;
    logic        irq_hi;
    logic        irq_lo;
    logic        irq;
    logic [31:0] q;
    logic [9:0]  seq [4];
    int          n_fail;
    int          checks_done;
    int          cycles;
    eic3_row_s   rows [8];
    // Edges from request to sampled ack: request edge plus answer edge
    localparam int ACK_WAIT = 2;

    eic3_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .ext_in1_i(pins[0]), .ext_in2_i(pins[1]), .ext_in3_i(pins[2]),
        .irq_high_o(irq_hi), .irq_low_o(irq_lo), .irq_o(irq));
    eic3_pins_model pm (.clk_i(clk_i), .pins_o(pins));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Hang guard; a good run takes under two hundred cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail = n_fail + 1;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Classic cycle: request held until ack is sampled, then a gap
    task automatic wb(input logic [4:0] a, input logic w, input logic [3:0] s,
                      input logic [31:0] d);
        int n;
        n = 0;
        adr <= a;
        we <= w;
        sel <= s;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        // No cycle cap here; the hang guard ends a stuck wait
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1);
        chk("ack wait", ACK_WAIT, n);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
        chk("ack drop", 32'h0, {31'h0, ack});
    endtask

    initial begin
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        rst_i = 1'b1;
        {adr, wdat, we, sel, cyc, stb} = '0;
        rows[0] = '{EIC3_OFF_CTRL, 4'h1, 32'h0000_003F, 32'h0000_0038};
        rows[1] = '{EIC3_OFF_CTRL, 4'h0, 32'h0000_0000, 32'h0000_0038};
        rows[2] = '{EIC3_OFF_CTRL, 4'h1, 32'h0000_00C0, 32'h0000_00C0};
        rows[3] = '{EIC3_OFF_EVT_MSK, 4'h1, 32'h0000_00FF, 32'h0000_0007};
        rows[4] = '{5'h14, 4'h1, 32'h0000_00FF, 32'h0000_0000};
        rows[5] = '{EIC3_OFF_EDGE, 4'h1, 32'h0000_00FF, 32'h0000_0007};
        rows[6] = '{EIC3_OFF_PIN_LVL, 4'h1, 32'h0000_00FF, 32'h0000_0000};
        rows[7] = '{EIC3_OFF_CTRL, 4'h1, 32'h0000_0000, 32'h0000_0000};
        // Control byte, then expected high and low requests
        seq = '{10'h07D, 10'h17F, 10'h092, 10'h080};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(EIC3_OFF_CTRL, 1'b0, 4'hF, 32'h0);
        chk("ctrl reset", 32'h0000_00C0, q);
        foreach (rows[i]) begin
            wb(rows[i].off, 1'b1, rows[i].sel, rows[i].wd);
            wb(rows[i].off, 1'b0, 4'hF, 32'h0);
            chk("row", rows[i].ex, q);
        end
        // Events with every enable off
        for (int i = 0; i < 3; i++) pm.pulse(i);
        repeat (2) @(posedge clk_i);
        chk("irq hi lo", 32'h0, {30'h0, irq_hi, irq_lo});
        chk("irq", 32'h1, {31'h0, irq});
        wb(EIC3_OFF_CTRL, 1'b0, 4'hF, 32'h0);
        chk("flags", 32'h0000_0007, q);
        foreach (seq[i]) begin
            wb(EIC3_OFF_CTRL, 1'b1, 4'h1, {24'h0, seq[i][9:2]});
            repeat (2) @(posedge clk_i);
            chk("route", {30'h0, seq[i][1:0]}, {30'h0, irq_hi, irq_lo});
        end
        // Event on input three while its enable stays on, then irq_o masked and event status cleared
        pm.pulse(2);
        repeat (2) @(posedge clk_i);
        chk("in3 high", 32'h2, {30'h0, irq_hi, irq_lo});
        wb(EIC3_OFF_EVT_MSK, 1'b1, 4'h1, 32'h0);
        repeat (2) @(posedge clk_i);
        chk("masked", 32'h0, {31'h0, irq});
        wb(EIC3_OFF_EVT_STS, 1'b1, 4'h1, 32'h0000_0007);
        wb(EIC3_OFF_EVT_MSK, 1'b1, 4'h1, 32'h0000_0007);
        wb(EIC3_OFF_EVT_STS, 1'b0, 4'hF, 32'h0);
        chk("status", 32'h0, q);
        chk("irq clr", 32'h0, {31'h0, irq});
        // Falling edge on input one; its rise alone must not set the flag
        wb(EIC3_OFF_EDGE, 1'b1, 4'h1, 32'h0000_0006);
        wb(EIC3_OFF_CTRL, 1'b1, 4'h1, 32'h0000_0000);
        pm.level(0, 1'b1);
        repeat (2) @(posedge clk_i);
        wb(EIC3_OFF_CTRL, 1'b0, 4'hF, 32'h0);
        chk("no rise", 32'h0000_0000, q);
        wb(EIC3_OFF_PIN_LVL, 1'b0, 4'hF, 32'h0);
        chk("pin level", 32'h0000_0001, q);
        pm.level(0, 1'b0);
        repeat (2) @(posedge clk_i);
        wb(EIC3_OFF_CTRL, 1'b0, 4'hF, 32'h0);
        chk("fall flag", 32'h0000_0001, q);
        // Second reset with flags set and input three held high
        pm.level(2, 1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(EIC3_OFF_CTRL, 1'b0, 4'hF, 32'h0);
        chk("ctrl again", 32'h0000_00C0, q);
        conclude();
    end
endmodule

bind eic3_top eic3_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .ext_in1_i(ext_in1_i), .ext_in2_i(ext_in2_i), .ext_in3_i(ext_in3_i),
    .irq_high_o(irq_high_o), .irq_low_o(irq_low_o), .irq_o(irq_o));

// file: common/eic3_if.sv
/*
 * Carrier between the register front end and the flag latch block.
 * Assumes both ends share one clock; no crossing happens here.
 */
`timescale 1ns/100ps
interface eic3_if #(
    parameter int N = 3
);
    logic [N-1:0] pin_lvl;   // Current input levels
    logic [N-1:0] edge_rise; // Per input: 1 = rising, 0 = falling
    logic [N-1:0] evt;       // One-cycle event pulses
    logic [N-1:0] flag;      // Latched occurrence flags
    logic         clr_we;    // Software write to the flag field
    logic [N-1:0] clr_keep;  // Written flag bits; zero clears

    modport latch (
        input  pin_lvl,
        input  edge_rise,
        input  clr_we,
        input  clr_keep,
        output evt,
        output flag
    );

    modport ctrl (
        output pin_lvl,
        output edge_rise,
        output clr_we,
        output clr_keep,
        input  evt,
        input  flag
    );
endinterface

// file: common/eic3_pkg.sv
/*
 * Constants for the external interrupt control bank: register byte offsets,
 * field positions, reset values and bus widths.
 * Assumes a 32-bit classic Wishbone register bus with byte addressing.
 */
package eic3_pkg;

    // Bus shape
    localparam int          EIC3_DATA_W      = 32;
    localparam int          EIC3_SEL_W       = 4;
    localparam int          EIC3_ADDR_W      = 5;
    localparam int          EIC3_NUM_IN      = 3;

    // Register byte offsets
    localparam logic [4:0]  EIC3_OFF_CTRL    = 5'h0_0; // external_irq_control_three
    localparam logic [4:0]  EIC3_OFF_EVT_STS = 5'h0_4; // sticky event status, W1C
    localparam logic [4:0]  EIC3_OFF_EVT_MSK = 5'h0_8; // event mask
    localparam logic [4:0]  EIC3_OFF_PIN_LVL = 5'h0_C; // pin levels, read only
    localparam logic [4:0]  EIC3_OFF_EDGE    = 5'h1_0; // edge select, 1 = rising

    // Field positions inside external_irq_control_three
    localparam int          EIC3_BIT_IN2_PRI = 7;
    localparam int          EIC3_BIT_IN1_PRI = 6;
    localparam int          EIC3_BIT_EN_HI   = 5;
    localparam int          EIC3_BIT_EN_LO   = 3;
    localparam int          EIC3_BIT_FLG_HI  = 2;
    localparam int          EIC3_BIT_FLG_LO  = 0;

    // Reset values
    localparam logic [1:0]  EIC3_RST_PRI     = 2'h3;
    localparam logic [2:0]  EIC3_RST_EN      = 3'h0;
    localparam logic [2:0]  EIC3_RST_FLG     = 3'h0;
    localparam logic [2:0]  EIC3_RST_EVT     = 3'h0;
    localparam logic [2:0]  EIC3_RST_MSK     = 3'h0;
    localparam logic [2:0]  EIC3_RST_EDGE    = 3'h7;
    localparam logic [31:0] EIC3_RD_ZERO     = 32'h0000_0000;

endpackage

// file: hdl/eic3_flags.sv
/*
 * Edge detection and occurrence flag latches for the external inputs.
 * Assumes pin levels already synchronous to clk_i.
 */
`timescale 1ns/100ps
module eic3_flags
    import eic3_pkg::*;
#(
    parameter int N = EIC3_NUM_IN
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    eic3_if.latch     lp
);

    logic [N-1:0] prev_q;
    logic         primed_q;
    logic [N-1:0] flag_q;
    logic [N-1:0] flag_d;

    // Previous level; first cycle after reset only samples
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q   <= '0;
            primed_q <= 1'b0;
        end else begin
            prev_q   <= lp.pin_lvl;
            primed_q <= 1'b1;
        end
    end

    // edge raises event
    // Priming avoids a false edge from a pin already high at reset
    assign lp.evt = primed_q ? ((lp.edge_rise & lp.pin_lvl & ~prev_q)
                              | (~lp.edge_rise & ~lp.pin_lvl & prev_q)) : '0;

    always_comb begin
        flag_d = flag_q;
        if (lp.clr_we) begin
            flag_d = flag_q & lp.clr_keep;
        end
        flag_d = flag_d | lp.evt; // Set wins over a same-cycle clear
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= EIC3_RST_FLG;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign lp.flag = flag_q;

endmodule

// file: hdl/eic3_top.sv
/*
 * External interrupt control bank: one control/status byte for three
 * external inputs, with priority routing, enables and occurrence flags,
 * plus event status, mask, pin level and edge select registers.
 *
 * Register words, byte offsets, data in the low bits:
 *   0x00 control byte: priorities, enables, occurrence flags
 *   0x04 event status, write one to clear
 *   0x08 event mask for irq_o
 *   0x0C pin levels, read only
 *   0x10 edge select, one picks the rising edge
 * Unmapped words read as zero; writes there are dropped.
 * Input three has no priority bit and always requests at the high level.
 *
 * Assumes a classic Wishbone master on clk_i and synchronous pin inputs.
 * Pins must already be synchronous to clk_i; there is no synchroniser here.
 * Writes land on the edge at which the master samples ack high.
 */
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
// Functional notes
// - Bit 7 sets input two priority, bit 6 input one; one is high.
// - Bits 5..3 enable inputs three, two, one; zero blocks requests.
// - Bits 2..0 are occurrence flags, set when the input's event occurs.
// - Flags stay set until software writes zero to them.
// - Flags set regardless of the input enable or global enable.
`timescale 1ns/100ps
module eic3_top
    import eic3_pkg::*;
#(
    parameter int ADDR_W = EIC3_ADDR_W
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic [ADDR_W-1:0]      wb_adr_i,
    input  wire logic [EIC3_DATA_W-1:0] wb_dat_i,
    output logic      [EIC3_DATA_W-1:0] wb_dat_o,
    input  wire logic                   wb_we_i,
    input  wire logic [EIC3_SEL_W-1:0]  wb_sel_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    output logic                        wb_ack_o,
    input  wire logic                   ext_in1_i,
    input  wire logic                   ext_in2_i,
    input  wire logic                   ext_in3_i,
    output logic                        irq_high_o,
    output logic                        irq_low_o,
    output logic                        irq_o
);

    localparam int N = EIC3_NUM_IN;

    // Word match on address; byte lane bits are ignored
    function automatic logic adr_hit(input logic [ADDR_W-1:0] adr,
                                     input logic [4:0]        off);
        adr_hit = (adr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    eic3_if #(.N(N)) lk ();

    // Bus side state
    logic             ack_q;
    logic [31:0]      dat_q;
    logic [31:0]      rd_d;
    logic             acc;

    // Write strobes, one per writable word
    logic             wr_lane0;
    logic             wr_ctrl;
    logic             wr_sts;
    logic             wr_msk;
    logic             wr_edge;

    // Control byte fields; the flags live in the latch block
    logic [1:0]       prio_q;
    logic [N-1:0]     en_q;
    logic [7:0]       ctrl_byte;

    // Event side: edge select, sticky status and its mask
    logic [N-1:0]     edge_q;
    logic [N-1:0]     evt_sts_q;
    logic [N-1:0]     evt_msk_q;

    // Request routing and the registered interrupt outputs
    logic [N-1:0]     req;
    logic [N-1:0]     high_sel;
    logic             irq_high_q;
    logic             irq_low_q;
    logic             irq_q;

    // Access is taken once per request; ack drops the cycle after
    assign acc      = wb_cyc_i & wb_stb_i & ~ack_q;
    // Writes land on the answer edge, where the master samples ack high;
    // a request dropped before its ack leaves every register untouched
    assign wr_lane0 = wb_cyc_i & wb_stb_i & ack_q & wb_we_i & wb_sel_i[0];
    assign wr_ctrl  = wr_lane0 & adr_hit(wb_adr_i, EIC3_OFF_CTRL);
    assign wr_sts   = wr_lane0 & adr_hit(wb_adr_i, EIC3_OFF_EVT_STS);
    assign wr_msk   = wr_lane0 & adr_hit(wb_adr_i, EIC3_OFF_EVT_MSK);
    assign wr_edge  = wr_lane0 & adr_hit(wb_adr_i, EIC3_OFF_EDGE);

    // Pins and flag clears toward the latch block
    assign lk.pin_lvl   = {ext_in3_i, ext_in2_i, ext_in1_i};
    assign lk.edge_rise = edge_q;
    assign lk.clr_we    = wr_ctrl;
    assign lk.clr_keep  = wb_dat_i[EIC3_BIT_FLG_HI:EIC3_BIT_FLG_LO];

    eic3_flags #(
        .N (N)
    ) u_flags (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lp    (lk)
    );

    // Bus acknowledge, one cycle after the request appears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prio_q <= EIC3_RST_PRI;
            en_q   <= EIC3_RST_EN;
        end else if (wr_ctrl) begin
            prio_q <= wb_dat_i[EIC3_BIT_IN2_PRI:EIC3_BIT_IN1_PRI];
            en_q   <= wb_dat_i[EIC3_BIT_EN_HI:EIC3_BIT_EN_LO];
        end
    end

    // Edge select per input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_q <= EIC3_RST_EDGE;
        end else if (wr_edge) begin
            edge_q <= wb_dat_i[N-1:0];
        end
    end

    // Event status, write one to clear; a new event wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_sts_q <= EIC3_RST_EVT;
        end else begin
            evt_sts_q <= (evt_sts_q & ~(wr_sts ? wb_dat_i[N-1:0] : '0)) | lk.evt;
        end
    end

    // Event mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_msk_q <= EIC3_RST_MSK;
        end else if (wr_msk) begin
            evt_msk_q <= wb_dat_i[N-1:0];
        end
    end

    // Control byte as software sees it
    assign ctrl_byte = {prio_q, en_q, lk.flag};

    // Read mux; unmapped words read as zero and still acknowledge
    always_comb begin
        rd_d = EIC3_RD_ZERO;
        if (adr_hit(wb_adr_i, EIC3_OFF_CTRL)) begin
            rd_d[7:0] = ctrl_byte;
        end else if (adr_hit(wb_adr_i, EIC3_OFF_EVT_STS)) begin
            rd_d[N-1:0] = evt_sts_q;
        end else if (adr_hit(wb_adr_i, EIC3_OFF_EVT_MSK)) begin
            rd_d[N-1:0] = evt_msk_q;
        end else if (adr_hit(wb_adr_i, EIC3_OFF_PIN_LVL)) begin
            rd_d[N-1:0] = lk.pin_lvl;
        end else if (adr_hit(wb_adr_i, EIC3_OFF_EDGE)) begin
            rd_d[N-1:0] = edge_q;
        end
    end

    // Read data captured with the ack, held until the next read access
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= EIC3_RD_ZERO;
        end else if (acc && !wb_we_i) begin
            dat_q <= rd_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;

    // request routing
    // Input three has no priority bit and always goes high
    assign req      = lk.flag & en_q;
    assign high_sel = {1'b1, prio_q};

    // Registered requests: one cycle from flag or enable change
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_high_q <= 1'b0;
            irq_low_q  <= 1'b0;
        end else begin
            irq_high_q <= |(req & high_sel);
            irq_low_q  <= |(req & ~high_sel);
        end
    end

    // Summary interrupt from unmasked event status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_sts_q & evt_msk_q);
        end
    end

    assign irq_high_o = irq_high_q;
    assign irq_low_o  = irq_low_q;
    assign irq_o      = irq_q;

endmodule
